// >>> adcc_pkg.sv
// package of constants and types for the converter control block
package adcc_pkg;
  localparam logic [11:0] ADCC_OFS_CTRL   = 12'h000;
  localparam logic [11:0] ADCC_OFS_RESULT = 12'h004;
  localparam logic [11:0] ADCC_OFS_AMP    = 12'h008;
  localparam logic [11:0] ADCC_OFS_ISTAT  = 12'h00C;
  localparam logic [11:0] ADCC_OFS_IMASK  = 12'h010;
  localparam int ADCC_BIT_DONE  = 7;
  localparam int ADCC_BIT_FAST  = 6;
  localparam int ADCC_BIT_POWER = 5;
  localparam int ADCC_BIT_SLOW  = 3;
  localparam int ADCC_BIT_AMP_SELECT = 2;
  localparam logic [7:0] ADCC_CTRL_WMASK = 8'h67;
  localparam logic [7:0] ADCC_AMP_WMASK  = 8'h0C;
  localparam logic [7:0] ADCC_RST_VAL    = 8'h00;
  localparam logic [2:0] ADCC_CHAN_MAX   = 3'h4;
  // converter clock cycles taken by one conversion
  localparam logic [3:0] ADCC_CONV_TICKS = 4'h9;
  localparam logic [1:0] ADCC_DIV_MAX    = 2'h3;
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_CONV = 2'b01,
    ADCC_WAIT = 2'b10
  } adcc_state_t;
endpackage

// >>> adcc_conv_if.sv
// interface between control logic and conversion sequencer
`timescale 1ns/1ps
interface adcc_conv_if;
  logic       start;
  logic       abort;
  logic       tick;
  logic       done;
  logic [7:0] data;
  modport ctrl (output start, output abort, output tick, input done, input data);
  modport seq  (input start, input abort, input tick, output done, output data);
endinterface

// >>> adcc_seq.sv
// conversion sequencer: counts converter ticks and returns the sampled byte
`timescale 1ns/1ps
module adcc_seq
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  // control side
  adcc_conv_if.seq   cv,
  // analog front end result, synchronised by caller
  input  wire logic [7:0] sample_i
);
  typedef struct packed {
    adcc_state_t st;
    logic [3:0]  cnt;
    logic        done;
    logic [7:0]  data;
  } adcc_seq_s_t;
  adcc_seq_s_t s_r;
  adcc_seq_s_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    unique case (s_r.st)
      ADCC_IDLE: begin
        if (cv.start) begin
          s_nxt.st = ADCC_CONV;
          s_nxt.cnt = 4'h0;
        end
      end
      ADCC_CONV: begin
        if (cv.tick) begin
          if (s_r.cnt == ADCC_CONV_TICKS - 4'h1) begin
            s_nxt.st = ADCC_WAIT;
          end else begin
            s_nxt.cnt = s_r.cnt + 4'h1;
          end
        end
      end
      ADCC_WAIT: begin
        s_nxt.done = 1'b1;
        s_nxt.data = sample_i;
        s_nxt.st = ADCC_IDLE;
      end
      default: s_nxt.st = ADCC_IDLE;
    endcase
    // abort wins; a start in the same cycle restarts at once
    if (cv.abort) begin
      s_nxt.done = 1'b0;
      s_nxt.cnt = 4'h0;
      s_nxt.st = cv.start ? ADCC_CONV : ADCC_IDLE;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign cv.done = s_r.done;
  assign cv.data = s_r.data;
endmodule

// >>> adcc_top.sv
// converter control registers with apb slave, clock divider and interrupt
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // analog front end
  input  wire logic [7:0]  sample_i,
  output logic             power_on_o,
  output logic             amp_route_o,
  output logic [2:0]       channel_o,
  output logic             conv_tick_o,
  // interrupt
  output logic             irq_o
);
  import adcc_pkg::*;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  result;
    logic [7:0]  amp;
    logic [1:0]  div;
    logic        istat;
    logic        imask;
    logic [7:0]  smp1;
    logic [7:0]  smp2;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        start;
    logic        irq;
    logic        tick;
    logic        route;
  } adcc_top_s_t;

  adcc_top_s_t s_r;
  adcc_top_s_t s_nxt;
  adcc_conv_if cv ();

  logic acc;
  logic wr;
  logic rd;
  logic tick_c;
  logic pwr;

  assign acc = psel_i & penable_i & ~s_r.pready;
  assign wr  = acc & pwrite_i;
  assign rd  = acc & ~pwrite_i;
  assign pwr = s_r.ctrl[ADCC_BIT_POWER];

  // converter clock enable from cpu clock
  always_comb begin
    if (s_r.amp[ADCC_BIT_SLOW]) begin
      tick_c = (s_r.div == ADCC_DIV_MAX);
    end else if (s_r.ctrl[ADCC_BIT_FAST]) begin
      tick_c = 1'b1;
    end else begin
      tick_c = s_r.div[0];
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.pready = acc;
    s_nxt.pslverr = 1'b0;
    s_nxt.start = 1'b0;
    // sample bus comes from analog domain
    s_nxt.smp1 = sample_i;
    s_nxt.smp2 = s_r.smp1;
    s_nxt.div = pwr ? s_r.div + 2'h1 : 2'h0;
    s_nxt.tick = pwr & tick_c;
    if (rd) begin
      unique case (paddr_i)
        ADCC_OFS_CTRL:   s_nxt.prdata = {24'h0, s_r.ctrl};
        ADCC_OFS_RESULT: s_nxt.prdata = {24'h0, s_r.result};
        ADCC_OFS_AMP:    s_nxt.prdata = {24'h0, s_r.amp};
        ADCC_OFS_ISTAT:  s_nxt.prdata = {31'h0, s_r.istat};
        ADCC_OFS_IMASK:  s_nxt.prdata = {31'h0, s_r.imask};
        default: begin
          s_nxt.prdata = 32'h0;
          s_nxt.pslverr = 1'b1;
        end
      endcase
      if (paddr_i == ADCC_OFS_RESULT) begin
        s_nxt.ctrl[ADCC_BIT_DONE] = 1'b0;
      end
    end
    if (wr) begin
      unique case (paddr_i)
        ADCC_OFS_CTRL: begin
          // reserved 4:3 dropped; flag cleared by any write
          s_nxt.ctrl = pwdata_i[7:0] & ADCC_CTRL_WMASK;
          s_nxt.start = pwdata_i[ADCC_BIT_POWER];
        end
        ADCC_OFS_AMP:   s_nxt.amp = pwdata_i[7:0] & ADCC_AMP_WMASK;
        ADCC_OFS_ISTAT: s_nxt.istat = s_r.istat & ~pwdata_i[0];
        ADCC_OFS_IMASK: s_nxt.imask = pwdata_i[0];
        ADCC_OFS_RESULT: s_nxt.pslverr = 1'b1;
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    // a result arriving with a clear still sets the flag;
    // a done just after a restart belongs to the aborted run
    if (cv.done & pwr & ~s_r.start) begin
      s_nxt.result = cv.data;
      s_nxt.ctrl[ADCC_BIT_DONE] = 1'b1;
      s_nxt.istat = 1'b1;
    end
    s_nxt.irq = s_nxt.istat & s_nxt.imask;
    s_nxt.route = s_nxt.amp[ADCC_BIT_AMP_SELECT] & s_nxt.ctrl[ADCC_BIT_POWER];
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // restart on a powered control write; power-off aborts too
  assign cv.start   = s_r.start;
  assign cv.abort   = s_r.start | ~pwr;
  assign cv.tick    = s_r.tick;

  adcc_seq u_seq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cv       (cv.seq),
    .sample_i (s_r.smp2)
  );

  assign prdata_o    = s_r.prdata;
  assign pready_o    = s_r.pready;
  assign pslverr_o   = s_r.pslverr;
  assign power_on_o  = s_r.ctrl[ADCC_BIT_POWER];
  assign amp_route_o = s_r.route;
  assign channel_o   = s_r.ctrl[2:0];
  assign conv_tick_o = s_r.tick;
  assign irq_o       = s_r.irq;
endmodule

// >>> adcc_monitor.sv
// port checker for the converter control block
`timescale 1ns/1ps
module adcc_monitor
  import adcc_pkg::*;
(
  input wire logic        clk_i, rst_i, psel_i, penable_i, pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic        pready_o, pslverr_o, power_on_o, amp_route_o, conv_tick_o, irq_o,
  input wire logic [2:0]  channel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire acc = psel_i && penable_i && !pready_o;
  rdy_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready held");
  one_wait_a: assert property (acc |=> pready_o) else $error("pready late");
  err_rdy_a: assert property (pslverr_o |-> pready_o) else $error("pslverr alone");
  result_ro_a: assert property (acc && pwrite_i && paddr_i == ADCC_OFS_RESULT |=> pslverr_o)
    else $error("result write taken");
  tick_pwr_a: assert property (conv_tick_o |-> power_on_o || $past(power_on_o))
    else $error("tick unpowered");
  off_quiet_a: assert property ((!power_on_o) [*2] |-> !conv_tick_o) else $error("tick after off");
  amp_pwr_a: assert property (amp_route_o |-> power_on_o || $past(power_on_o))
    else $error("amp routed unpowered");
  rst_zero_a: assert property ($fell(rst_i) |-> !power_on_o && !amp_route_o && channel_o == 3'h0 && !irq_o)
    else $error("outputs not clear");
  cover property (conv_tick_o);
  cover property ($rose(irq_o));
  cover property (pslverr_o);
endmodule
bind adcc_top adcc_monitor adcc_monitor_i (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pready_o,
  .pslverr_o, .power_on_o, .amp_route_o, .conv_tick_o, .irq_o, .channel_o);

// >>> adcc_afe_model.sv
// analog front end stand-in returning a channel-coded byte
`timescale 1ns/1ps
module adcc_afe_model (
  input  wire logic       clk_i,
  input  wire logic       power_i,
  input  wire logic [2:0] channel_i,
  output logic      [7:0] sample_o
);
  initial sample_o = 8'h5A;
  // unpowered front end toggles, so a stale capture shows
  always @(posedge clk_i)
    sample_o <= power_i ? {5'h15, channel_i} : ~sample_o;
endmodule

// >>> adcc_top_test.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adcc_top_test;
  import adcc_pkg::*;
  logic        clk_i = 0, rst_i = 1, psel = 0, pen = 0, pwr = 0, se, rdy, err, pon, amp, tick, irq;
  logic [11:0] pa = '0;
  logic [31:0] pwd = '0, prd, q;
  logic [7:0]  smp;
  logic [2:0]  chan;
  int          err_total = 0, checked = 0, n;
  always #4 clk_i = ~clk_i;
  adcc_top adcc_top_i (.clk_i, .rst_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(rdy), .pslverr_o(err), .sample_i(smp), .power_on_o(pon), .amp_route_o(amp),
    .channel_o(chan), .conv_tick_o(tick), .irq_o(irq));
  adcc_afe_model adcc_afe_model_i (.clk_i, .power_i(pon), .channel_i(chan), .sample_o(smp));
  task automatic close_out;
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // two idle edges so registered outputs settle before checks
  task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk_i) pen <= 1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    if (rdy !== 1'b1) begin
      cmp("pready", 1, rdy);
      close_out();
    end
    q = prd;
    se = err;
    psel <= 0;
    pen <= 0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wdone;
    n = 0;
    do begin
      ap(0, ADCC_OFS_CTRL, '0);
      n++;
    end while (q[7] !== 1'b1 && n < 30);
    cmp("done", 1, q[7]);
    if (q[7] !== 1'b1)
      close_out();
  endtask
  task automatic cnt(input int e);
    n = 0;
    repeat (40) @(posedge clk_i) n += int'(tick === 1'b1);
    cmp("ticks", 1, n >= e - 1 && n <= e + 1);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (int i = 0; i < 3; i++) begin
      ap(0, 12'(4 * i), '0);
      cmp("reset", '0, q);
    end
    ap(1, ADCC_OFS_AMP, 32'hFF);
    ap(0, ADCC_OFS_AMP, '0);
    cmp("amp", 32'h0C, q);
    cmp("route off", 0, amp);
    ap(1, ADCC_OFS_IMASK, 32'h1);
    for (int c = 0; c < 5; c++) begin
      ap(1, ADCC_OFS_CTRL, 32'h20 + c);
      cmp("channel", c, chan);
    end
    cmp("power", 1, pon);
    cmp("route", 1, amp);
    wdone();
    ap(0, ADCC_OFS_RESULT, '0);
    cmp("result", 32'hAC, q);
    cmp("irq", 1, irq);
    ap(0, ADCC_OFS_CTRL, '0);
    cmp("flag read", 0, q[7]);
    ap(1, ADCC_OFS_ISTAT, 32'h1);
    cmp("irq clr", 0, irq);
    ap(1, ADCC_OFS_CTRL, 32'h21);
    ap(1, ADCC_OFS_CTRL, 32'h22);
    wdone();
    ap(1, ADCC_OFS_CTRL, 32'h23);
    ap(0, ADCC_OFS_CTRL, '0);
    cmp("flag write", 0, q[7]);
    wdone();
    ap(0, ADCC_OFS_RESULT, '0);
    cmp("restart", 32'hAB, q);
    ap(1, ADCC_OFS_CTRL, 32'h04);
    cnt(0);
    ap(0, ADCC_OFS_RESULT, '0);
    cmp("held", 32'hAB, q);
    for (int i = 0; i < 4; i++) begin
      ap(1, ADCC_OFS_AMP, i > 1 ? 32'h08 : 32'h00);
      ap(1, ADCC_OFS_CTRL, i[0] ? 32'h60 : 32'h20);
      cnt(i == 1 ? 40 : i == 0 ? 20 : 10);
    end
    // settings changed while running: first result is thrown away
    ap(0, ADCC_OFS_RESULT, '0);
    ap(1, ADCC_OFS_CTRL, 32'h20);
    wdone();
    ap(1, ADCC_OFS_RESULT, 32'hFF);
    cmp("ro err", 1, se);
    ap(0, ADCC_OFS_RESULT, '0);
    cmp("ro", 32'hA8, q);
    ap(0, 12'h020, '0);
    cmp("unmapped", 1, se);
    cmp("unmapped data", '0, q);
    close_out();
  end
endmodule
